//--- rtl/dss_server.sv
// Purpose: long and short disk command sequencer of a disk server
// Assumes: transport byte streams and disk engine on clk_i
// Notes: read data of short commands is not carried here
//
// Summary of operation
// - arming a receive socket writes FEh into its return code.
// - a finished send leaves a send return code below 80h.
// - an arrival sets return code 00h and records sender and length.
// - a sector write's Results carry only the return code, length one.
// - control bytes and user data leave an arrival on separate paths.
// - at most one request is held per network device.
// - Go goes out only once the disk can take the remaining bytes.
// - a host in service has up to BURST (20h) commands served before the scan moves on.
// - the protocol version is kept separately for every host.
// - each command's version follows the socket it arrived on.
// - the new protocol keeps the same four-message long sequence.
// - the Go reply is the two bytes G and O.
// - a set top bit in the G byte tells the client the disk reset.
`timescale 1ns/10ps
`include "dss_cfg.svh"
module dss_server
  import dss_pkg::*;
#(
  parameter int NHOST = 64,
  parameter logic [5:0] BURST = `DSS_BURST_MAX
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic reset_n_i, // sync reset, low
  input wire logic rx_valid_i, // incoming byte present
  input wire logic rx_last_i, // last byte of message
  input wire logic rx_ctrl_i, // byte is control info
  input wire logic [7:0] rx_data_i, // incoming byte
  input wire logic [7:0] rx_socket_i, // target socket
  input wire logic [7:0] rx_src_i, // sender address
  output logic tx_valid_o, // outgoing byte offered
  input wire logic tx_ready_i, // outgoing byte taken
  output logic tx_ctrl_o, // byte is control info
  output logic tx_last_o, // last byte of message
  output logic [7:0] tx_data_o, // outgoing byte
  output logic [7:0] tx_socket_o, // target socket
  output logic [7:0] tx_dest_o, // destination host
  output logic dsk_cmd_valid_o, // command to disk
  output logic [31:0] dsk_cmd_o, // opcode and address
  output logic dsk_long_o, // command has a Last part
  input wire logic dsk_ready_i, // disk takes remainder
  output logic dsk_wdata_valid_o, // remainder byte strobe
  output logic [7:0] dsk_wdata_o, // remainder byte
  input wire logic dsk_done_i, // command finished
  input wire logic [7:0] dsk_retcode_i, // disk return code
  input wire logic dsk_reset_i, // disk was reset
  output logic [7:0] req_rc_o, // request socket code
  output logic [7:0] last_rc_o, // last socket code
  output logic [7:0] send_rc_o, // send code
  output logic refused_o // request dropped pulse
);
  localparam int HOST_W = $clog2(NHOST);

  dss_state_t state, next_state;
  logic [HOST_W-1:0] cur_host, next_cur, serv_host, next_serv;
  logic [HOST_W-1:0] req_host;
  logic [5:0] burst_cnt, next_burst;
  logic serv_new, next_serv_new, serv_long, next_serv_long;
  logic [31:0] cmd_q, next_cmd;
  logic [NHOST-1:0] pending, next_pending, proto_new, next_proto;
  logic [NHOST-1:0] q_long, next_qlong;
  logic [31:0] q_cmd [NHOST];
  logic [31:0] next_qcmd [NHOST];
  logic refused, next_refused, rst_flag, next_rst_flag;
  logic [15:0] stg_m, next_stg_m;
  logic [31:0] stg_cmd, next_stg_cmd;
  logic commit, next_commit;
  logic req_armed, req_done, req_cwe, req_dwe;
  logic [7:0] req_src, req_sock, req_byte;
  logic [15:0] req_idx;
  logic last_armed, last_done, last_dwe;
  logic [7:0] last_byte;
  logic tx_start, tx_busy, tx_done, arm_last;
  dss_msg_t tx_kind;

  // ==========================================================
  // receive sockets
  // request socket answers on the old and new request sockets
  dss_rx_sock #(
    .SOCK_A(`DSS_SOCK_REQ_OLD),
    .SOCK_B(`DSS_SOCK_REQ_NEW)
  ) u_req (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .arm_i(!req_armed),
    .rx_valid_i(rx_valid_i),
    .rx_last_i(rx_last_i),
    .rx_ctrl_i(rx_ctrl_i),
    .rx_data_i(rx_data_i),
    .rx_socket_i(rx_socket_i),
    .rx_src_i(rx_src_i),
    .armed_o(req_armed),
    .rc_o(req_rc_o),
    .src_o(req_src),
    .sock_o(req_sock),
    .len_o(),
    .done_o(req_done),
    .ctrl_we_o(req_cwe),
    .data_we_o(req_dwe),
    .idx_o(req_idx),
    .byte_o(req_byte)
  );

  dss_rx_sock #(
    .SOCK_A(`DSS_SOCK_LAST),
    .SOCK_B(`DSS_SOCK_LAST)
  ) u_last (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .arm_i(arm_last),
    .rx_valid_i(rx_valid_i),
    .rx_last_i(rx_last_i),
    .rx_ctrl_i(rx_ctrl_i),
    .rx_data_i(rx_data_i),
    .rx_socket_i(rx_socket_i),
    .rx_src_i(rx_src_i),
    .armed_o(last_armed),
    .rc_o(last_rc_o),
    .src_o(),
    .sock_o(),
    .len_o(),
    .done_o(last_done),
    .ctrl_we_o(),
    .data_we_o(last_dwe),
    .idx_o(),
    .byte_o(last_byte)
  );

  // ==========================================================
  // message sender
  dss_tx_msg u_tx (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(tx_start),
    .kind_i(tx_kind),
    .new_i(serv_new),
    .rst_flag_i(rst_flag),
    .retcode_i(dsk_retcode_i),
    .dest_i(8'(serv_host)),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .rc_o(send_rc_o),
    .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i),
    .tx_ctrl_o(tx_ctrl_o),
    .tx_last_o(tx_last_o),
    .tx_data_o(tx_data_o),
    .tx_socket_o(tx_socket_o),
    .tx_dest_o(tx_dest_o)
  );

  // Go only once the disk can take the remainder
  assign arm_last = state == st_wait_rdy && dsk_ready_i;
  assign tx_start = arm_last || (state == st_wait_done && dsk_done_i);
  assign tx_kind = state == st_wait_rdy ? dss_msg_go : dss_msg_res;

  // ==========================================================
  // request staging
  // commit one cycle after arrival so the last byte is in
  always_comb begin
    next_stg_m = stg_m;
    next_stg_cmd = stg_cmd;
    next_commit = req_done;
    if (commit) begin
      next_stg_m = 16'h0000;
      next_stg_cmd = 32'h00000000;
    end
    if (req_cwe && req_idx < 16'h0002) begin
      next_stg_m[{~req_idx[0], 3'b000} +: 8] = req_byte;
    end
    if (req_dwe && req_idx < 16'h0004) begin
      next_stg_cmd[{~req_idx[1:0], 3'b000} +: 8] = req_byte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stg_m <= 16'h0000;
      stg_cmd <= 32'h00000000;
      commit <= 1'b0;
    end else begin
      stg_m <= next_stg_m;
      stg_cmd <= next_stg_cmd;
      commit <= next_commit;
    end
  end

  assign req_host = req_src[HOST_W-1:0];

  // ==========================================================
  // queue and sequencer
  always_comb begin
    next_state = state;
    next_cur = cur_host;
    next_burst = burst_cnt;
    next_serv = serv_host;
    next_serv_new = serv_new;
    next_serv_long = serv_long;
    next_cmd = cmd_q;
    next_pending = pending;
    next_proto = proto_new;
    next_qlong = q_long;
    next_qcmd = q_cmd;
    next_refused = 1'b0;
    next_rst_flag = rst_flag;
    if (commit) begin
      if (pending[req_host]) begin
        next_refused = 1'b1;
      end else begin
        next_pending[req_host] = 1'b1;
        next_qcmd[req_host] = stg_cmd;
        next_qlong[req_host] = stg_m > `DSS_SHORT_MAX;
        // version follows the socket the request came in on
        next_proto[req_host] =
          req_sock == `DSS_SOCK_REQ_NEW;
      end
    end
    case (state)
      st_idle: begin
        if (pending[cur_host] && burst_cnt < BURST) begin
          next_serv = cur_host;
          next_serv_new = proto_new[cur_host];
          next_serv_long = q_long[cur_host];
          next_cmd = q_cmd[cur_host];
          next_burst = burst_cnt + 6'd1;
          next_state = st_issue;
        end else begin
          next_burst = 6'd0;
          if (cur_host == HOST_W'(NHOST - 1)) begin
            next_cur = '0;
          end else begin
            next_cur = cur_host + 1'b1;
          end
        end
      end
      st_issue: begin
        next_state = serv_long ? st_wait_rdy : st_wait_done;
      end
      st_wait_rdy: begin
        if (dsk_ready_i) begin
          next_state = st_go;
        end
      end
      st_go: begin
        if (tx_done) begin
          next_state = st_last;
        end
      end
      st_last: begin
        if (last_done) begin
          next_state = st_wait_done;
        end
      end
      st_wait_done: begin
        if (dsk_done_i) begin
          next_state = st_res;
        end
      end
      st_res: begin
        if (tx_done) begin
          next_pending[serv_host] = 1'b0;
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // a reset seen while Go starts is kept for the next Go
    if (dsk_reset_i) begin
      next_rst_flag = 1'b1;
    end else if (arm_last) begin
      next_rst_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= st_idle;
      cur_host <= '0;
      burst_cnt <= 6'd0;
      serv_host <= '0;
      serv_new <= 1'b0;
      serv_long <= 1'b0;
      cmd_q <= 32'h00000000;
      pending <= '0;
      proto_new <= '0;
      q_long <= '0;
      q_cmd <= '{default: 32'h00000000};
      refused <= 1'b0;
      rst_flag <= 1'b0;
    end else begin
      state <= next_state;
      cur_host <= next_cur;
      burst_cnt <= next_burst;
      serv_host <= next_serv;
      serv_new <= next_serv_new;
      serv_long <= next_serv_long;
      cmd_q <= next_cmd;
      pending <= next_pending;
      proto_new <= next_proto;
      q_long <= next_qlong;
      q_cmd <= next_qcmd;
      refused <= next_refused;
      rst_flag <= next_rst_flag;
    end
  end

  assign dsk_cmd_valid_o = state == st_issue;
  assign dsk_cmd_o = cmd_q;
  assign dsk_long_o = serv_long;
  assign dsk_wdata_valid_o = state == st_last && last_dwe;
  assign dsk_wdata_o = last_byte;
  assign refused_o = refused;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_go_sent;
    state == st_go && tx_done;
  endsequence
  sequence s_long_issue;
    state == st_issue && serv_long;
  endsequence
  a_one_queued: assert property (
    commit && pending[req_host] |=> refused_o && $stable(pending))
    else $error("second request from one device was queued");
  a_go_ready: assert property (
    state == st_go && $past(state) != st_go |-> $past(dsk_ready_i))
    else $error("go sent before disk ready");
  a_burst_cap: assert property (
    burst_cnt == BURST && state == st_idle |=> state == st_idle)
    else $error("more than burst commands from one host");
  a_proto_host: assert property (
    commit && !pending[req_host] |=> proto_new[$past(req_host)] ==
      ($past(req_sock) == `DSS_SOCK_REQ_NEW))
    else $error("protocol version not tracked per host");
  a_long_order: assert property (
    s_long_issue |=> state == st_wait_rdy)
    else $error("long command skipped its go phase");
  a_go_to_last: assert property (
    s_go_sent |=> state == st_last && last_armed)
    else $error("last socket not armed after go");
  a_reset_bit: assert property (
    arm_last && rst_flag |=> tx_busy && tx_data_o[7] && !tx_ctrl_o)
    else $error("disk reset not shown in go byte");
endmodule

//--- rtl/dss_cfg.svh
// Purpose: shared constants of the disk server command sequencer
// Assumes: included by bare name from the server, socket and sender design files
// Notes: socket numbers, result codes and message bytes
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
// ==========================================================
// sockets
`define DSS_SOCK_REQ_OLD 8'hB0
`define DSS_SOCK_REQ_NEW 8'h80
`define DSS_SOCK_LAST 8'hA0
`define DSS_SOCK_GO_OLD 8'hB0
`define DSS_SOCK_GO_NEW 8'h80
`define DSS_SOCK_RES 8'hB0
// ==========================================================
// result record codes
`define DSS_RC_INIT 8'hFF
`define DSS_RC_ARMED 8'hFE
`define DSS_RC_REARM 8'h85
`define DSS_RC_RCVD 8'h00
`define DSS_RC_SENT 8'h00
`define DSS_RC_OK_LIM 8'h80
// ==========================================================
// message contents and counts
`define DSS_GO_HI 8'h47
`define DSS_GO_LO 8'h4F
`define DSS_RES_LEN_HI 8'h00
`define DSS_RES_LEN_LO 8'h01
`define DSS_SHORT_MAX 16'h0004
`define DSS_BURST_MAX 6'h20
`endif

//--- rtl/dss_pkg.sv
// Purpose: types of the disk server command sequencer
// Assumes: nothing
// Notes: constants live in dss_cfg.svh
package dss_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_issue,
    st_wait_rdy,
    st_go,
    st_last,
    st_wait_done,
    st_res
  } dss_state_t;
  typedef enum logic {
    dss_msg_go,
    dss_msg_res
  } dss_msg_t;
endpackage

//--- rtl/dss_rx_sock.sv
// Purpose: one receive socket with its result record
// Assumes: byte stream from the transport on the same clock
// Notes: control bytes and user data leave on separate strobes
`timescale 1ns/10ps
`include "dss_cfg.svh"
module dss_rx_sock
  import dss_pkg::*;
#(
  parameter logic [7:0] SOCK_A = `DSS_SOCK_LAST,
  parameter logic [7:0] SOCK_B = `DSS_SOCK_LAST
) (
  input wire logic clk_i, // clock
  input wire logic reset_n_i, // sync reset, low
  input wire logic arm_i, // set up the socket
  input wire logic rx_valid_i, // byte present
  input wire logic rx_last_i, // last byte of message
  input wire logic rx_ctrl_i, // byte is control info
  input wire logic [7:0] rx_data_i, // byte
  input wire logic [7:0] rx_socket_i, // target socket
  input wire logic [7:0] rx_src_i, // sender address
  output logic armed_o, // socket armed
  output logic [7:0] rc_o, // return code
  output logic [7:0] src_o, // source host
  output logic [7:0] sock_o, // socket hit
  output logic [15:0] len_o, // user data length
  output logic done_o, // message received pulse
  output logic ctrl_we_o, // control byte strobe
  output logic data_we_o, // user data strobe
  output logic [15:0] idx_o, // byte index in area
  output logic [7:0] byte_o // byte out
);
  logic armed, next_armed, done, next_done, cwe, next_cwe;
  logic dwe, next_dwe, hit;
  logic [7:0] rc, next_rc, src, next_src, sock, next_sock;
  logic [7:0] byte_q, next_byte;
  logic [15:0] len, next_len, ccnt, next_ccnt, dcnt, next_dcnt;
  logic [15:0] idx, next_idx;

  assign hit = armed && rx_valid_i &&
               (rx_socket_i == SOCK_A || rx_socket_i == SOCK_B);

  always_comb begin
    next_armed = armed;
    next_rc = rc;
    next_src = src;
    next_sock = sock;
    next_len = len;
    next_ccnt = ccnt;
    next_dcnt = dcnt;
    next_idx = idx;
    next_byte = byte_q;
    next_done = 1'b0;
    next_cwe = 1'b0;
    next_dwe = 1'b0;
    if (hit) begin
      next_byte = rx_data_i;
      next_cwe = rx_ctrl_i;
      next_dwe = !rx_ctrl_i;
      next_idx = rx_ctrl_i ? ccnt : dcnt;
      if (rx_ctrl_i) begin
        next_ccnt = ccnt + 16'h0001;
      end else begin
        next_dcnt = dcnt + 16'h0001;
      end
      if (rx_last_i) begin
        next_armed = 1'b0;
        next_rc = `DSS_RC_RCVD;
        next_src = rx_src_i;
        next_sock = rx_socket_i;
        next_len = rx_ctrl_i ? dcnt : dcnt + 16'h0001;
        next_done = 1'b1;
      end
    end else if (arm_i) begin
      if (armed) begin
        next_rc = `DSS_RC_REARM;
      end else begin
        next_armed = 1'b1;
        next_rc = `DSS_RC_ARMED;
        next_ccnt = 16'h0000;
        next_dcnt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      armed <= 1'b0;
      rc <= `DSS_RC_INIT;
      src <= 8'h00;
      sock <= 8'h00;
      len <= 16'h0000;
      ccnt <= 16'h0000;
      dcnt <= 16'h0000;
      idx <= 16'h0000;
      byte_q <= 8'h00;
      done <= 1'b0;
      cwe <= 1'b0;
      dwe <= 1'b0;
    end else begin
      armed <= next_armed;
      rc <= next_rc;
      src <= next_src;
      sock <= next_sock;
      len <= next_len;
      ccnt <= next_ccnt;
      dcnt <= next_dcnt;
      idx <= next_idx;
      byte_q <= next_byte;
      done <= next_done;
      cwe <= next_cwe;
      dwe <= next_dwe;
    end
  end

  assign armed_o = armed;
  assign rc_o = rc;
  assign src_o = src;
  assign sock_o = sock;
  assign len_o = len;
  assign done_o = done;
  assign ctrl_we_o = cwe;
  assign data_we_o = dwe;
  assign idx_o = idx;
  assign byte_o = byte_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_arm_sets_code: assert property (
    arm_i && !armed && !hit |=> rc_o == `DSS_RC_ARMED && armed_o)
    else $error("arming did not report socket set up");
  a_rcv_record: assert property (
    hit && rx_last_i |=> done_o && rc_o == `DSS_RC_RCVD &&
      src_o == $past(rx_src_i) && !armed_o)
    else $error("arrival not recorded in result record");
  a_split_area: assert property (
    hit |=> ctrl_we_o == $past(rx_ctrl_i) && ctrl_we_o != data_we_o)
    else $error("control and data bytes not split");
endmodule

//--- rtl/dss_tx_msg.sv
// Purpose: sends Go and Results messages byte by byte
// Assumes: transport takes a byte when tx_valid_o and tx_ready_i
// Notes: send return code is FFh while busy, 00h when done
`timescale 1ns/10ps
`include "dss_cfg.svh"
module dss_tx_msg
  import dss_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic reset_n_i, // sync reset, low
  input wire logic start_i, // start a message
  input wire dss_msg_t kind_i, // go or results
  input wire logic new_i, // new protocol
  input wire logic rst_flag_i, // disk was reset
  input wire logic [7:0] retcode_i, // disk return code
  input wire logic [7:0] dest_i, // destination host
  output logic busy_o, // message in flight
  output logic done_o, // message sent pulse
  output logic [7:0] rc_o, // send return code
  output logic tx_valid_o, // byte offered
  input wire logic tx_ready_i, // byte taken
  output logic tx_ctrl_o, // byte is control info
  output logic tx_last_o, // last byte
  output logic [7:0] tx_data_o, // byte
  output logic [7:0] tx_socket_o, // target socket
  output logic [7:0] tx_dest_o // destination host
);
  logic busy, next_busy, done, next_done, ctl, next_ctl;
  logic [1:0] cnt, next_cnt;
  logic [23:0] sh, next_sh;
  logic [7:0] rc, next_rc, sock, next_sock, dest, next_dest;
  logic [7:0] go_hi;

  // top bit of G tells the client to restart the operation
  assign go_hi = `DSS_GO_HI | {rst_flag_i, 7'h00};

  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_sh = sh;
    next_rc = rc;
    next_ctl = ctl;
    next_sock = sock;
    next_dest = dest;
    next_done = 1'b0;
    if (!busy && start_i) begin
      next_busy = 1'b1;
      next_rc = `DSS_RC_INIT;
      next_dest = dest_i;
      if (kind_i == dss_msg_go) begin
        next_sh = {go_hi, `DSS_GO_LO, 8'h00};
        next_cnt = 2'd2;
        next_ctl = 1'b0;
        next_sock = new_i ? `DSS_SOCK_GO_NEW : `DSS_SOCK_GO_OLD;
      end else begin
        // results: length 1 and return code, no user data
        next_sh = {`DSS_RES_LEN_HI, `DSS_RES_LEN_LO, retcode_i};
        next_cnt = 2'd3;
        next_ctl = 1'b1;
        next_sock = `DSS_SOCK_RES;
      end
    end else if (busy && tx_ready_i) begin
      next_sh = {sh[15:0], 8'h00};
      next_cnt = cnt - 2'd1;
      if (cnt == 2'd1) begin
        next_busy = 1'b0;
        next_rc = `DSS_RC_SENT;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      busy <= 1'b0;
      cnt <= 2'd0;
      sh <= 24'h000000;
      rc <= `DSS_RC_INIT;
      ctl <= 1'b0;
      sock <= 8'h00;
      dest <= 8'h00;
      done <= 1'b0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      sh <= next_sh;
      rc <= next_rc;
      ctl <= next_ctl;
      sock <= next_sock;
      dest <= next_dest;
      done <= next_done;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign rc_o = rc;
  assign tx_valid_o = busy;
  assign tx_ctrl_o = ctl;
  assign tx_last_o = busy && cnt == 2'd1;
  assign tx_data_o = sh[23:16];
  assign tx_socket_o = sock;
  assign tx_dest_o = dest;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_go_start;
    !busy && start_i && kind_i == dss_msg_go && !rst_flag_i;
  endsequence
  a_sent_code: assert property (
    busy && tx_ready_i && tx_last_o |=> done_o && !busy_o &&
      rc_o < `DSS_RC_OK_LIM)
    else $error("send completion code not below 80h");
  a_go_bytes: assert property (
    s_go_start |=> tx_valid_o && !tx_ctrl_o &&
      tx_data_o == `DSS_GO_HI && !tx_last_o)
    else $error("go message does not open with G");
  a_res_shape: assert property (
    !busy && start_i && kind_i == dss_msg_res |=> tx_ctrl_o &&
      tx_data_o == `DSS_RES_LEN_HI && cnt == 2'd3)
    else $error("results message shape wrong");
endmodule

//--- tb/dss_client.sv
// Purpose: client host model on the network side
// Assumes: bytes move on the rising edge of clk_i
// Notes: idle data lines show the inverse of the last byte
`timescale 1ns/10ps
module dss_client (
  input wire logic clk_i, // clock
  input wire logic slow_i, // take a byte every other cycle
  input wire logic tx_valid_i, // byte offered
  input wire logic tx_ctrl_i, // control byte
  input wire logic [7:0] tx_data_i, // byte
  input wire logic [7:0] tx_socket_i, // socket
  output logic tx_ready_o, // byte taken
  output logic rx_valid_o, // byte present
  output logic rx_last_o, // last byte
  output logic rx_ctrl_o, // control byte
  output logic [7:0] rx_data_o, // byte
  output logic [7:0] rx_socket_o, // socket
  output logic [7:0] rx_src_o // our address
);
  // control M=516 then opcode 33h and address
  logic [7:0] pat [8] = '{8'h02, 8'h04, 8'h00, 8'h00,
    8'h33, 8'h01, 8'h00, 8'h00};
  logic [7:0] got [16];
  logic [7:0] sk [16];
  logic ct [16];
  int n = 0;
  logic tk = 1'b1;
  initial begin
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_ctrl_o = 1'b0;
    rx_data_o = 8'h00;
    rx_socket_o = 8'h00;
    rx_src_o = 8'h00;
  end
  assign tx_ready_o = tk;
  always @(posedge clk_i) begin
    tk <= slow_i ? ~tk : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      got[n] <= tx_data_i;
      sk[n] <= tx_socket_i;
      ct[n] <= tx_ctrl_i;
      n <= n + 1;
    end
  end
  // same message sequence in both versions, only sockets differ
  task automatic msg(input logic [7:0] s, input logic [7:0] h,
      input int nc, input int nb);
    rx_socket_o = s;
    rx_src_o = h;
    for (int i = 0; i < nb; i++) begin
      rx_valid_o = 1'b1;
      rx_ctrl_o = i < nc;
      rx_data_o = (i < 8) ? pat[i] : i[7:0];
      rx_last_o = i == nb - 1;
      @(posedge clk_i);
      #1;
    end
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule

//--- tb/tb.sv
// Purpose: bench of the disk server sequencer
// Assumes: the bench plays the disk engine
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
`define WT(c) begin k = 0; while (!(c) && k < 900) begin \
  @(posedge clk_i); #1; k++; end if (k >= 900) begin failures++; \
  finish_test(); end end
module tb;
  logic clk_i = 0, reset_n_i = 0, slow = 0, dr = 0, dd = 0, drs = 0;
  logic [7:0] drc = 8'h5A, lw = 8'h00;
  logic rv, rl, rc, tv, tr, tc, tl, cv, lg, wv, rf;
  logic [7:0] rd, rs, rsrc, td, ts, tdst, wd, qrc, lrc, snd;
  logic [31:0] cmd;
  int failures = 0, n_compared = 0, k, nw = 0, nr = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (reset_n_i) begin
      nw <= nw + wv;
      nr <= nr + rf;
      if (wv) lw <= wd;
    end
  end
  dss_server dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rx_valid_i(rv),
    .rx_last_i(rl), .rx_ctrl_i(rc), .rx_data_i(rd), .rx_socket_i(rs),
    .rx_src_i(rsrc), .tx_valid_o(tv), .tx_ready_i(tr), .tx_ctrl_o(tc),
    .tx_last_o(tl), .tx_data_o(td), .tx_socket_o(ts), .tx_dest_o(tdst),
    .dsk_cmd_valid_o(cv), .dsk_cmd_o(cmd), .dsk_long_o(lg),
    .dsk_ready_i(dr), .dsk_wdata_valid_o(wv), .dsk_wdata_o(wd),
    .dsk_done_i(dd), .dsk_retcode_i(drc), .dsk_reset_i(drs),
    .req_rc_o(qrc), .last_rc_o(lrc), .send_rc_o(snd), .refused_o(rf));
  dss_client cl (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(tv),
    .tx_ctrl_i(tc), .tx_data_i(td), .tx_socket_i(ts), .tx_ready_o(tr),
    .rx_valid_o(rv), .rx_last_o(rl), .rx_ctrl_o(rc), .rx_data_o(rd),
    .rx_socket_o(rs), .rx_src_o(rsrc));
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // old protocol sector write from host 1
  task automatic t_long();
    `WT(qrc === 8'hFE)
    `CHK("req armed", 8'hFE, qrc)
    cl.msg(8'hB0, 8'h01, 4, 8);
    `CHK("req rcvd", 8'h00, qrc)
    `WT(cv === 1'b1)
    `CHK("cmd", 32'h33010000, cmd)
    `CHK("long", 1'b1, lg)
    repeat (5) @(posedge clk_i);
    #1;
    `CHK("no early go", 1'b0, tv)
    dr = 1;
    `WT(cl.n == 2)
    `CHK("go g", 8'h47, cl.got[0])
    `CHK("go o", 8'h4F, cl.got[1])
    `CHK("go dest", 8'h01, tdst)
    `WT(lrc === 8'hFE)
    `CHK("send", 1'b1, snd < 8'h80)
    cl.msg(8'hA0, 8'h01, 0, 512);
    @(posedge clk_i);
    #1;
    `CHK("last bytes", 512, nw)
    `CHK("last byte", 8'hFF, lw)
    dd = 1;
    `WT(cl.n == 5)
    dd = 0;
    `CHK("res len", 16'h0001, {cl.got[2], cl.got[3]})
    `CHK("res code", 8'h5A, cl.got[4])
    `CHK("res ctrl", 1'b1, cl.ct[4])
    dr = 0;
    $display("long write done");
  endtask
  // ==========================================================
  // new protocol, second request refused, disk reset, slow client
  task automatic t_refuse();
    slow = 1;
    drs = 1;
    `WT(qrc === 8'hFE)
    cl.msg(8'h80, 8'h02, 4, 8);
    `WT(cv === 1'b1)
    repeat (3) @(posedge clk_i);
    #1;
    cl.msg(8'h80, 8'h02, 4, 8);
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("refused", 1, nr)
    dr = 1;
    `WT(cl.n == 7)
    drs = 0;
    `CHK("go reset", 8'hC7, cl.got[5])
    `CHK("go sock", 8'h80, cl.sk[5])
    `CHK("go dest 2", 8'h02, tdst)
    `WT(lrc === 8'hFE)
    cl.msg(8'hA0, 8'h02, 0, 4);
    drc = 8'h3C;
    dd = 1;
    `WT(cl.n == 10)
    dd = 0;
    `CHK("res sock", 8'hB0, cl.sk[9])
    `CHK("res code 2", 8'h3C, cl.got[9])
    `CHK("last total", 516, nw)
    $display("refuse and new protocol done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    reset_n_i = 1;
    t_long();
    t_refuse();
    finish_test();
  end
endmodule
